/* File: design/msb_bridge.sv */
// Mixed speed bus bridge: switch control between a high-speed bus
// section and a standard/fast section, plus current-source gating.
// Assumes the pass gates and pull-down are external transistors and
// that the bus lines arrive unsynchronised from pins.
`timescale 1ns/1ps
`include "msb_map.svh"

module msb_bridge (
	// Core clock domain
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	// Link clock domain of the local master
	input  wire logic link_clk_in,
	input  wire logic link_rst_in,
	input  wire logic master_active_in,
	// Bus lines as seen at the pins
	input  wire logic sda_h_in,
	input  wire logic scl_h_in,
	input  wire logic sda_l_in,
	input  wire logic scl_l_in,
	// Slow data line pull-down, open drain
	output logic      sda_l_out,
	output logic      sda_l_oe_out,
	// Switch controls and status
	output logic      data_pass_gate_out,
	output logic      clock_pass_gate_out,
	output logic      high_speed_operation_out,
	output logic      clock_current_source_out
);

	localparam int HANG_CYC = `MSB_HANG_CYC;
	localparam int BUF_CYC  = `MSB_BUF_CYC;

	msb_pkg::msb_core_t r;
	msb_pkg::msb_core_t next_r;
	msb_pkg::msb_link_t l;
	msb_pkg::msb_link_t next_l;

	logic start_ev;
	logic stop_ev;
	logic scl_rise;
	logic scl_fall;
	logic ack_end;
	logic hang_hit;
	logic buf_hit;

	function automatic logic msb_has_prefix(input logic [7:0] code,
		input logic [4:0] prefix);
		return code[7:3] == prefix;
	endfunction : msb_has_prefix

	// Events come from the filtered levels only, never from raw pins
	assign start_ev = r.prev[`MSB_SDA_H] && !r.lvl[`MSB_SDA_H]
		&& r.prev[`MSB_SCL_H] && r.lvl[`MSB_SCL_H];
	assign stop_ev  = !r.prev[`MSB_SDA_H] && r.lvl[`MSB_SDA_H]
		&& r.prev[`MSB_SCL_H] && r.lvl[`MSB_SCL_H];
	assign scl_rise = !r.prev[`MSB_SCL_H] && r.lvl[`MSB_SCL_H];
	assign scl_fall = r.prev[`MSB_SCL_H] && !r.lvl[`MSB_SCL_H];
	assign ack_end  = scl_fall && r.inframe && r.bitcnt == `MSB_ACK_BIT;
	assign hang_hit = r.state != msb_pkg::MSB_FS && !r.lvl[`MSB_SCL_L]
		&& r.hang_cnt == 8'(HANG_CYC - 1);
	assign buf_hit  = r.buf_cnt == 8'(BUF_CYC - 1);

	always_comb
	begin
		next_r = r;
		// Three stages; a change counts once stages two and three agree
		next_r.s1   = {scl_l_in, sda_l_in, scl_h_in, sda_h_in};
		next_r.s2   = r.s1;
		next_r.s3   = r.s2;
		// Agreeing stages set the level either way; disagreement holds it
		next_r.lvl  = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));
		next_r.prev = r.lvl;

		// Byte framing, shared by slow and high-speed phases
		if (start_ev)
		begin
			next_r.bitcnt  = 4'h0;
			next_r.first   = 1'b1;
			next_r.inframe = 1'b1;
		end
		else if (stop_ev)
		begin
			next_r.bitcnt  = 4'h0;
			next_r.first   = 1'b0;
			next_r.inframe = 1'b0;
		end
		else if (scl_rise && r.inframe)
		begin
			if (r.bitcnt < `MSB_DATA_BITS)
				next_r.shreg = {r.shreg[6:0], r.lvl[`MSB_SDA_H]};
			else
				next_r.nack = r.lvl[`MSB_SDA_H];
			next_r.bitcnt = r.bitcnt + 4'h1;
		end
		else if (ack_end)
		begin
			next_r.bitcnt = 4'h0;
			next_r.first  = 1'b0;
		end

		// Slow clock held low while separated counts toward a hang
		if (r.state != msb_pkg::MSB_FS && !r.lvl[`MSB_SCL_L])
			next_r.hang_cnt = r.hang_cnt + 8'h01;
		else
			next_r.hang_cnt = 8'h00;

		case (r.state)
			msb_pkg::MSB_FS:
			begin
				// Joined bus; current source off in slow operation
				next_r.dpg     = 1'b1;
				next_r.cpg     = 1'b1;
				next_r.pd      = 1'b0;
				next_r.cs_want = 1'b0;
				// The NACK after the code is relied on before splitting
				if (ack_end && r.first && r.nack
					&& msb_has_prefix(r.shreg, `MSB_HS_PREFIX))
				begin
					next_r.state = msb_pkg::MSB_SEP_DATA;
					next_r.dpg   = 1'b0;
				end
				// A reserved code simply stays here at slow speed
			end
			msb_pkg::MSB_SEP_DATA:
			begin
				// Pull-down only after the data gate has opened
				next_r.pd    = 1'b1;
				next_r.state = msb_pkg::MSB_SEP_PULL;
			end
			msb_pkg::MSB_SEP_PULL:
			begin
				if (r.lvl[`MSB_SCL_H] && r.lvl[`MSB_SCL_L])
				begin
					next_r.cpg     = 1'b0;
					next_r.cs_want = 1'b1;
					next_r.state   = msb_pkg::MSB_HS;
				end
			end
			msb_pkg::MSB_HS:
			begin
				// Slow section parked: clock floats high, data held low
				next_r.dpg = 1'b0;
				next_r.cpg = 1'b0;
				next_r.pd  = 1'b1;
				if (stop_ev)
				begin
					next_r.cs_want = 1'b0;
					next_r.cpg     = 1'b1;
					next_r.pd      = 1'b0;
					next_r.buf_cnt = 8'h00;
					next_r.state   = msb_pkg::MSB_RECON;
				end
				else if (ack_end || start_ev)
					next_r.cs_want = 1'b0;
				else if (scl_rise)
					next_r.cs_want = 1'b1;
			end
			msb_pkg::MSB_RECON:
			begin
				next_r.buf_cnt = r.buf_cnt + 8'h01;
				// A line that never rises must not keep the bus split
				if (r.lvl[`MSB_SDA_L] || buf_hit)
				begin
					next_r.dpg   = 1'b1;
					next_r.state = msb_pkg::MSB_FS;
				end
			end
			default:
			begin
				next_r.state = msb_pkg::MSB_FS;
			end
		endcase

		// Hang recovery overrides every state
		if (hang_hit)
		begin
			next_r.dpg     = 1'b1;
			next_r.cpg     = 1'b1;
			next_r.pd      = 1'b0;
			next_r.cs_want = 1'b0;
			next_r.state   = msb_pkg::MSB_FS;
		end

		if (!ce_in)
			next_r = r;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			r          <= '0;
			r.s1       <= `MSB_RST_LINES;
			r.s2       <= `MSB_RST_LINES;
			r.s3       <= `MSB_RST_LINES;
			r.lvl      <= `MSB_RST_LINES;
			r.prev     <= `MSB_RST_LINES;
			r.state    <= msb_pkg::MSB_FS;
			r.dpg      <= `MSB_RST_GATE;
			r.cpg      <= `MSB_RST_GATE;
			r.pd       <= `MSB_RST_PULL;
		end
		else
			r <= next_r;
	end

	// Link domain: current source of the local master. The request is a
	// level, so two flops suffice; it lags by up to three link cycles.
	always_comb
	begin
		next_l       = l;
		next_l.cs_s1 = r.cs_want;
		next_l.cs_s2 = l.cs_s1;
		next_l.cs    = l.cs_s2 && master_active_in;
	end

	always_ff @(posedge link_clk_in)
	begin
		if (link_rst_in)
			l <= '0;
		else
			l <= next_l;
	end

	assign sda_l_out                = 1'b0;
	assign sda_l_oe_out             = r.pd;
	assign data_pass_gate_out       = r.dpg;
	assign clock_pass_gate_out      = r.cpg;
	// One-hot: the high-speed state bit is itself a flop
	assign high_speed_operation_out = r.state[3];
	assign clock_current_source_out = l.cs;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in || !ce_in);

	AST_FS_JOINED: assert property (
		r.state == msb_pkg::MSB_FS && $past(r.state) == msb_pkg::MSB_FS
		|-> r.dpg && r.cpg && !r.pd && !r.cs_want)
		else $error("slow operation without both gates closed");

	AST_HS_PARKED: assert property (
		r.state == msb_pkg::MSB_HS && $past(r.state) == msb_pkg::MSB_HS
		&& !$past(stop_ev) |-> !r.dpg && !r.cpg && r.pd)
		else $error("high speed without sections separated and parked");

	AST_MC_SPLIT: assert property (
		r.state == msb_pkg::MSB_FS && ack_end && r.first && r.nack
		&& msb_has_prefix(r.shreg, `MSB_HS_PREFIX) && !hang_hit
		|=> r.state == msb_pkg::MSB_SEP_DATA ##1
		r.state == msb_pkg::MSB_SEP_PULL)
		else $error("master code did not start separation");

	AST_RSV_STAY: assert property (
		r.state == msb_pkg::MSB_FS && ack_end && r.first
		&& msb_has_prefix(r.shreg, `MSB_RSV_PREFIX)
		|=> r.state == msb_pkg::MSB_FS [*2])
		else $error("reserved code separated the sections");

	AST_PD_ORDER: assert property (
		$rose(r.pd) |-> !r.dpg && !$past(r.dpg))
		else $error("pull-down on before data gate opened");

	AST_CPG_OPEN: assert property (
		$fell(r.cpg)
		|-> $past(r.lvl[`MSB_SCL_H]) && $past(r.lvl[`MSB_SCL_L]))
		else $error("clock gate opened while a clock line was low");

	AST_HANG: assert property (
		r.state != msb_pkg::MSB_FS && !r.lvl[`MSB_SCL_L]
		&& r.hang_cnt == 8'(HANG_CYC - 1)
		|=> r.state == msb_pkg::MSB_FS && r.dpg && r.cpg && !r.pd)
		else $error("slow clock hang did not rejoin the sections");

	AST_STOP: assert property (
		r.state == msb_pkg::MSB_HS && stop_ev && !hang_hit
		|=> r.state == msb_pkg::MSB_RECON && r.cpg && !r.pd
		&& !r.cs_want && !r.dpg)
		else $error("high-speed stop not handled");

	AST_DPG_LATE: assert property (
		$rose(r.dpg) && $past(r.state) == msb_pkg::MSB_RECON
		&& !$past(hang_hit)
		|-> $past(r.lvl[`MSB_SDA_L]) || $past(r.buf_cnt) == 8'(BUF_CYC - 1))
		else $error("data gate closed before slow data rose");

	AST_BUF: assert property (
		$rose(r.state == msb_pkg::MSB_RECON)
		|-> ##[1:BUF_CYC] r.state == msb_pkg::MSB_FS)
		else $error("reconnection exceeded bus free time");

	AST_ACK_CS: assert property (
		r.state == msb_pkg::MSB_HS && ack_end && !hang_hit
		|=> !r.cs_want)
		else $error("current source left on after acknowledge");

	AST_SYNC_AGREE: assert property (
		r.s2 == r.s3 |=> r.lvl == $past(r.s2))
		else $error("filtered lines did not follow agreeing stages");

	AST_MC_CS: assert property (
		r.state == msb_pkg::MSB_SEP_PULL && r.lvl[`MSB_SCL_H]
		&& r.lvl[`MSB_SCL_L] && !hang_hit
		|=> r.state == msb_pkg::MSB_HS && !r.cpg && r.cs_want)
		else $error("bad gate or source at high-speed start");

	AST_CS_RISE: assert property (
		r.state == msb_pkg::MSB_HS && scl_rise && !hang_hit
		|=> r.cs_want)
		else $error("current source not requested at clock high");

	AST_SR_CS: assert property (
		r.state == msb_pkg::MSB_HS && start_ev && !hang_hit
		|=> !r.cs_want && r.state == msb_pkg::MSB_HS)
		else $error("current source left on after repeated start");

	AST_STOP_CS: assert property (
		r.state == msb_pkg::MSB_HS && stop_ev && !hang_hit
		|=> !r.cs_want)
		else $error("current source left on after high-speed stop");

	AST_RECON_JOIN: assert property (
		r.state == msb_pkg::MSB_RECON && r.lvl[`MSB_SDA_L] && !hang_hit
		|=> r.state == msb_pkg::MSB_FS && r.dpg && r.cpg)
		else $error("slow data high but sections not rejoined");

endmodule : msb_bridge

/* File: design/msb_map.svh */
// Constants of the mixed speed bus bridge: line indices, reset values
// and timing counts.
// Assumes a 100 MHz core clock; all counts derive from that period.
`ifndef MSB_MAP_SVH
`define MSB_MAP_SVH

// Positions of the four bus lines in the sampled line vector
`define MSB_SDA_H 0
`define MSB_SCL_H 1
`define MSB_SDA_L 2
`define MSB_SCL_L 3

// Reset values: sections joined, pull-down and current source off
`define MSB_RST_GATE    1'b1
`define MSB_RST_PULL    1'b0
`define MSB_RST_LINES   4'hf

// Bit position of the acknowledge slot within a byte frame
`define MSB_ACK_BIT     4'h9
`define MSB_DATA_BITS   4'h8

// Master code prefixes in the top five bits of the first byte
`define MSB_HS_PREFIX   5'h01
`define MSB_RSV_PREFIX  5'h00

// Timing
`define MSB_CLK_PERIOD_NS 10
`define MSB_T_HANG_NS     1000
`define MSB_T_BUF_NS      1300
// Hang detection is a least time: round up
`define MSB_HANG_CYC ((`MSB_T_HANG_NS + `MSB_CLK_PERIOD_NS - 1) / `MSB_CLK_PERIOD_NS)
// Reconnection must finish inside bus free time: round down
`define MSB_BUF_CYC  (`MSB_T_BUF_NS / `MSB_CLK_PERIOD_NS)

`endif

/* File: design/msb_pkg.sv */
// Types of the mixed speed bus bridge: state encoding and the state
// records of the core and link clock domains.
// Assumes msb_map.svh is included by the design file.
package msb_pkg;

	typedef enum logic [4:0] {
		MSB_FS       = 5'h01,
		MSB_SEP_DATA = 5'h02,
		MSB_SEP_PULL = 5'h04,
		MSB_HS       = 5'h08,
		MSB_RECON    = 5'h10
	} msb_state_t;

	typedef struct packed {
		logic [3:0]  s1;
		logic [3:0]  s2;
		logic [3:0]  s3;
		logic [3:0]  lvl;
		logic [3:0]  prev;
		msb_state_t  state;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic        nack;
		logic        first;
		logic        inframe;
		logic [7:0]  hang_cnt;
		logic [7:0]  buf_cnt;
		logic        dpg;
		logic        cpg;
		logic        pd;
		logic        cs_want;
	} msb_core_t;

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs;
	} msb_link_t;

endpackage : msb_pkg

/* File: tb/msb_bus_model.sv */
// Bus model: the four open-drain wires of both sections and the gates.
// Assumes a pull-up on every line; pd_in and each device input is a request to pull low.
`timescale 1ns/1ps
module msb_bus_model (
	// Switch controls from the bridge
	input  wire logic dpg_in,
	input  wire logic cpg_in,
	input  wire logic pd_in,
	// Pull-low requests of the devices
	input  wire logic sda_h_low_in,
	input  wire logic scl_h_low_in,
	input  wire logic scl_l_low_in,
	// Wire levels
	output logic      sda_h_out,
	output logic      scl_h_out,
	output logic      sda_l_out,
	output logic      scl_l_out
);
	logic dh, ch, dl, cl;
	assign dh = !sda_h_low_in;
	assign ch = !scl_h_low_in;
	assign dl = !pd_in;
	assign cl = !scl_l_low_in;
	// A closed gate is wired-AND: a low on either side wins both ways
	assign sda_h_out = dpg_in ? (dh & dl) : dh;
	assign sda_l_out = dpg_in ? (dh & dl) : dl;
	assign scl_h_out = cpg_in ? (ch & cl) : ch;
	assign scl_l_out = cpg_in ? (ch & cl) : cl;
endmodule : msb_bus_model

/* File: tb/mixed_speed_bus_bridge_tb_top.sv */
// Testbench of the bridge: a master on the fast section and a slow
// device, joined through the bus model. Assumes a 100 MHz core clock.
`timescale 1ns/1ps
module mixed_speed_bus_bridge_tb_top;
	localparam int SQ = 63; // Quarter bit: 2.52 us per slow bit
	localparam int HQ = 8;
	logic clk = 0, link_clk = 0, rst = 1, link_rst = 1, act = 0;
	logic sdh_low = 0, sch_low = 0, scl_low = 0;
	logic dh, ch, dl, cl, sdl_drv, oe, dpg, cpg, hs, ccs;
	int   n_mismatch = 0, check_count = 0, cycles = 0;

	msb_bridge dut (.clk_in(clk), .rst_in(rst), .ce_in(1'b1),
		.link_clk_in(link_clk), .link_rst_in(link_rst),
		.master_active_in(act), .sda_h_in(dh), .scl_h_in(ch),
		.sda_l_in(dl), .scl_l_in(cl), .sda_l_out(sdl_drv),
		.sda_l_oe_out(oe), .data_pass_gate_out(dpg),
		.clock_pass_gate_out(cpg), .high_speed_operation_out(hs),
		.clock_current_source_out(ccs));
	msb_bus_model bus (.dpg_in(dpg), .cpg_in(cpg),
		.pd_in(oe & ~sdl_drv), .sda_h_low_in(sdh_low),
		.scl_h_low_in(sch_low), .scl_l_low_in(scl_low),
		.sda_h_out(dh), .scl_h_out(ch), .sda_l_out(dl), .scl_l_out(cl));

	initial
	begin
		forever #5 clk = ~clk;
	end
	initial
	begin
		#3;
		forever #80 link_clk = ~link_clk;
	end

	task automatic report_and_stop();
		if (n_mismatch == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic drive(input logic d, input logic c, input int q);
		sdh_low = !d;
		sch_low = !c;
		tick(q);
	endtask : drive

	task automatic start(input int q);
		drive(1, 0, q);
		drive(1, 1, q);
		drive(0, 1, q);
		drive(0, 0, q);
	endtask : start

	task automatic stop(input int q);
		drive(0, 0, q);
		drive(0, 1, q);
		drive(1, 1, q);
	endtask : stop

	task automatic send_bit(input logic b, input int q);
		drive(b, 0, q);
		drive(b, 1, 2 * q);
		drive(b, 0, q);
	endtask : send_bit

	task automatic send_byte(input logic [7:0] v, input int q);
		for (int i = 7; i >= 0; i--)
			send_bit(v[i], q);
		send_bit(1'b1, q); // Nobody acknowledges
	endtask : send_byte

	task automatic test_reserved();
		act = 1;
		start(SQ);
		send_byte(8'h05, SQ);
		tick(20);
		chk(dpg, 1'b1);
		chk(cpg, 1'b1);
		chk(hs, 1'b0);
		tick(60);
		chk(ccs, 1'b0);
		stop(SQ);
	endtask : test_reserved

	task automatic enter_hs(input logic [7:0] code);
		start(SQ);
		for (int i = 7; i >= 0; i--)
			send_bit(code[i], SQ);
		// NACK bit; poll from its falling clock to see the gate order
		drive(1, 0, SQ);
		drive(1, 1, 2 * SQ);
		drive(1, 0, 1);
		repeat (20) if (dpg !== 1'b0) tick(1);
		chk(dpg, 1'b0);
		chk(oe, 1'b0); // Gate first, pull-down after
		tick(1);
		chk(oe, 1'b1);
		tick(SQ);
		chk(cpg, 1'b1); // Clock still low, gate held
		drive(1, 1, SQ);
		chk(cpg, 1'b0);
		chk(hs, 1'b1);
		chk(dl, 1'b0);
		chk(cl, 1'b1);
	endtask : enter_hs

	task automatic test_hs();
		enter_hs(8'h09);
		chk(ccs, 1'b1);
		start(HQ);
		send_byte(8'ha4, HQ);
		chk(cl, 1'b1); // Slow clock unmoved by fast traffic
		tick(60);
		chk(ccs, 1'b0);
		drive(1, 1, 60);
		chk(ccs, 1'b1);
		stop(HQ);
		chk(cpg, 1'b1);
		chk(oe, 1'b0);
		chk(hs, 1'b0);
		chk(dpg, 1'b0); // Slow data not yet seen high
		repeat (130) if (dpg !== 1'b1) tick(1);
		chk(dpg, 1'b1); // Within bus free time
		tick(60);
		chk(ccs, 1'b0);
	endtask : test_hs

	task automatic test_hang();
		act = 0;
		enter_hs(8'h0f);
		chk(ccs, 1'b0); // Inactive master keeps its source off
		scl_low = 1;
		tick(90);
		chk(dpg, 1'b0); // Too short to count as a hang
		tick(20);
		chk(dpg, 1'b1);
		chk(cpg, 1'b1);
		chk(oe, 1'b0);
		scl_low = 0;
		stop(SQ);
	endtask : test_hang

	initial
	begin
		tick(20);
		rst = 0;
		link_rst = 0;
		tick(5);
		chk(dpg, 1'b1);
		chk(cpg, 1'b1);
		chk(oe, 1'b0);
		test_reserved();
		test_hs();
		test_hang();
		report_and_stop();
	end
endmodule : mixed_speed_bus_bridge_tb_top
